/* File: shared/ssp_consts.svh */
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// =====================================================================
// Status byte field positions
`define SSP_BIT_PIN_GUARD_EN  7
`define SSP_BIT_SERIAL_LOCK  6
`define SSP_BIT_GUARD_HIGH   3
`define SSP_BIT_GUARD_LOW    2
`define SSP_BIT_WRITE_LATCH  1
`define SSP_BIT_BUSY         0
`define SSP_STATUS_RESET     8'h00

// =====================================================================
// Opcodes
`define SSP_OP_STATUS_READ   8'h05
`define SSP_OP_STATUS_QUICK  8'h09
`define SSP_OP_STATUS_WRITE  8'h01
`define SSP_OP_LATCH_SET     8'h06
`define SSP_OP_LATCH_CLEAR   8'h04
`define SSP_OP_ARRAY_WRITE   8'h02
`define SSP_OP_CLOCK_WRITE   8'h12
`define SSP_OP_NV_SAVE       8'h3c
`define SSP_OP_NV_RESTORE    8'h60
`define SSP_OP_AUTOSAVE_ON   8'h59
`define SSP_OP_AUTOSAVE_OFF  8'h19
`define SSP_OP_SERIAL_WRITE  8'hc2

// =====================================================================
// Array protection thresholds and synchroniser depth
`define SSP_QUARTER_BASE     16'hc000
`define SSP_HALF_BASE        16'h8000
`define SSP_SYNC_STAGES      2

`endif

/* File: shared/ssp_pkg.sv */
package ssp_pkg;

    typedef enum logic [2:0]
    {
        SSP_OPCODE,
        SSP_DUMMY,
        SSP_READ,
        SSP_WDATA,
        SSP_IGNORE
    } ssp_state_e;

    typedef logic [7:0] ssp_byte_t;

endpackage

/* File: rtl/ssp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"

// =====================================================================
// Two-stage synchroniser, one per bit
module ssp_sync
#(
    parameter int WIDTH = 4
)
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic meta_q;
            logic meta_d;
            logic hold_q;
            logic hold_d;
            always_comb
            begin
                meta_d = clk_en ? async_in[gi] : meta_q;
                hold_d = clk_en ? meta_q : hold_q;
            end
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    meta_q <= 1'b1;
                    hold_q <= 1'b1;
                end
                else
                begin
                    meta_q <= meta_d;
                    hold_q <= hold_d;
                end
            end
            assign sync_out[gi] = hold_q;
        end
    endgenerate

endmodule
`default_nettype wire

/* File: rtl/ssp_guard.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"

// =====================================================================
// Array protection level decode
module ssp_guard
(
    input  wire logic [1:0]  block_guard,
    input  wire logic [15:0] addr,
    output logic             addr_protected
);

    always_comb
    begin
        unique case (block_guard)
            2'h0: addr_protected = 1'b0;
            2'h1: addr_protected = (addr >= `SSP_QUARTER_BASE);
            2'h2: addr_protected = (addr >= `SSP_HALF_BASE);
            2'h3: addr_protected = 1'b1;
        endcase
    end

endmodule
`default_nettype wire

/* File: rtl/ssp_status.sv */
// How it works
// R01: Status byte: guard-en, lock, 0, 0, guards, latch, busy
// R02: Busy bit mirrors save or restore activity
// R03: Status write changes only bits 2,3,6,7 from its data, and clears latch bit 1
// R04: Bits 4 and 5 always read zero
// R05: All stored bits start at zero
// R06: Latch clear at power-up; gates writes
// R07: Serial writes refused once lock set
// R08: Lock sets once, never clears; the code clears it at reset
// R09: Plain read shifts status after opcode
// R10: Quick read skips one dummy byte first
// R11: Status write takes opcode plus eight bits
// R12: Write-class commands need latch set
// R13: Status persists only after save completes
// R14: Guard pin ignored while guard-enable clear
// R15: Block guard bits select protected array range
// R16: Latch-set command sets the latch
// R17: Finished write-class command clears latch
// R18: Latch-clear acts at chip-select rise
// R19: Pin low with guard-enable blocks status writes
// R20: Short status-write frame changes nothing
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"

module ssp_status
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        si,
    input  wire logic        wp_n,
    input  wire logic        busy_in,
    input  wire logic        nv_save_done,
    input  wire logic        nv_restore_valid,
    input  wire logic [7:0]  nv_restore_byte,
    input  wire logic [15:0] array_addr,
    output logic             so,
    output logic             so_oe,
    output logic [7:0]       status_byte,
    output logic [7:0]       nv_status_image,
    output logic             array_addr_protected,
    output logic             write_cmd_go,
    output logic [7:0]       write_cmd_code
);

    // =================================================================
    // Pin synchronisers
    logic [3:0] pins_s;
    logic       sck_s;
    logic       cs_n_s;
    logic       si_s;
    logic       wp_n_s;

    ssp_sync #(.WIDTH(4)) u_sync
    (
        .clk       (clk),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .async_in  ({wp_n, si, cs_n, sck}),
        .sync_out  (pins_s)
    );

    assign sck_s  = pins_s[0];
    assign cs_n_s = pins_s[1];
    assign si_s   = pins_s[2];
    assign wp_n_s = pins_s[3];

    // =================================================================
    // State
    ssp_pkg::ssp_state_e state_q, state_d;
    logic [2:0]          cnt_q, cnt_d;
    ssp_pkg::ssp_byte_t  sh_in_q, sh_in_d;
    ssp_pkg::ssp_byte_t  sh_out_q, sh_out_d;
    logic                sck_prev_q, sck_prev_d;
    logic                cs_prev_q, cs_prev_d;
    logic                so_q, so_d;
    logic                latch_q, latch_d;
    logic                pge_q, pge_d;
    logic                lock_q, lock_d;
    logic [1:0]          guard_q, guard_d;
    logic                busy_q, busy_d;
    logic                pend_clear_q, pend_clear_d;
    logic                pend_op_q, pend_op_d;
    ssp_pkg::ssp_byte_t  pend_code_q, pend_code_d;
    logic                go_q, go_d;
    ssp_pkg::ssp_byte_t  go_code_q, go_code_d;
    ssp_pkg::ssp_byte_t  image_q, image_d;
    logic                commit;

    logic               sel;
    logic               rise;
    logic               fall;
    logic               cs_rise;
    logic               done;
    ssp_pkg::ssp_byte_t byte_next;
    ssp_pkg::ssp_byte_t status_now;
    logic               pin_block;
    logic               write_class;

    always_comb
    begin
        sel        = ~cs_n_s;
        rise       = sck_s & ~sck_prev_q;
        fall       = ~sck_s & sck_prev_q;
        cs_rise    = cs_n_s & ~cs_prev_q;
        done       = sel & rise & (cnt_q == 3'h7);
        byte_next  = {sh_in_q[6:0], si_s};
        status_now = 8'h00;                                         // R04
        status_now[`SSP_BIT_PIN_GUARD_EN] = pge_q;                  // R01
        status_now[`SSP_BIT_SERIAL_LOCK]  = lock_q;
        status_now[`SSP_BIT_GUARD_HIGH]   = guard_q[1];
        status_now[`SSP_BIT_GUARD_LOW]    = guard_q[0];
        status_now[`SSP_BIT_WRITE_LATCH]  = latch_q;
        status_now[`SSP_BIT_BUSY]         = busy_q;                 // R02
        pin_block  = pge_q & ~wp_n_s;                               // R14 R19
        write_class = (byte_next == `SSP_OP_ARRAY_WRITE)
                    | (byte_next == `SSP_OP_CLOCK_WRITE)
                    | (byte_next == `SSP_OP_NV_SAVE)
                    | (byte_next == `SSP_OP_NV_RESTORE)
                    | (byte_next == `SSP_OP_AUTOSAVE_ON)
                    | (byte_next == `SSP_OP_AUTOSAVE_OFF)
                    | ((byte_next == `SSP_OP_SERIAL_WRITE) & ~lock_q);  // R07
    end

    // =================================================================
    // Next-state logic
    always_comb
    begin
        state_d      = state_q;
        cnt_d        = cnt_q;
        sh_in_d      = sh_in_q;
        sh_out_d     = sh_out_q;
        sck_prev_d   = sck_s;
        cs_prev_d    = cs_n_s;
        so_d         = so_q;
        latch_d      = latch_q;
        pge_d        = pge_q;
        lock_d       = lock_q;
        guard_d      = guard_q;
        busy_d       = busy_in;                                     // R02
        pend_clear_d = pend_clear_q;
        pend_op_d    = pend_op_q;
        pend_code_d  = pend_code_q;
        go_d         = 1'b0;
        go_code_d    = go_code_q;
        image_d      = image_q;
        commit       = 1'b0;

        if (!sel)
        begin
            state_d      = ssp_pkg::SSP_OPCODE;
            cnt_d        = 3'h0;
            pend_clear_d = 1'b0;
            pend_op_d    = 1'b0;
            if (cs_rise && pend_clear_q)
                latch_d = 1'b0;                                     // R18
            if (cs_rise && pend_op_q)
            begin
                latch_d   = 1'b0;                                   // R17
                go_d      = 1'b1;
                go_code_d = pend_code_q;
            end
        end
        else
        begin
            if (rise)
            begin
                sh_in_d = byte_next;
                cnt_d   = cnt_q + 3'h1;
            end
            if (fall && state_q == ssp_pkg::SSP_READ)
            begin
                so_d     = sh_out_q[7];                             // R09
                sh_out_d = {sh_out_q[6:0], 1'b0};
            end
            if (done)
            begin
                unique case (state_q)
                    ssp_pkg::SSP_OPCODE:
                    begin
                        state_d = ssp_pkg::SSP_IGNORE;
                        if (byte_next == `SSP_OP_STATUS_READ)
                        begin
                            state_d  = ssp_pkg::SSP_READ;           // R09
                            sh_out_d = status_now;
                        end
                        else if (byte_next == `SSP_OP_STATUS_QUICK)
                            state_d = ssp_pkg::SSP_DUMMY;           // R10
                        else if (byte_next == `SSP_OP_STATUS_WRITE)
                        begin
                            if (latch_q && !pin_block)              // R12 R19
                                state_d = ssp_pkg::SSP_WDATA;       // R11
                        end
                        else if (byte_next == `SSP_OP_LATCH_SET)
                            latch_d = 1'b1;                         // R16
                        else if (byte_next == `SSP_OP_LATCH_CLEAR)
                            pend_clear_d = 1'b1;                    // R18
                        else if (write_class && latch_q)            // R12
                        begin
                            pend_op_d   = 1'b1;
                            pend_code_d = byte_next;
                        end
                    end
                    ssp_pkg::SSP_DUMMY:
                    begin
                        state_d  = ssp_pkg::SSP_READ;               // R10
                        sh_out_d = status_now;
                    end
                    ssp_pkg::SSP_READ:
                        sh_out_d = status_now;
                    ssp_pkg::SSP_WDATA:
                    begin
                        commit  = 1'b1;                             // R20
                        state_d = ssp_pkg::SSP_IGNORE;
                        pge_d   = byte_next[`SSP_BIT_PIN_GUARD_EN]; // R03
                        guard_d = {byte_next[`SSP_BIT_GUARD_HIGH], byte_next[`SSP_BIT_GUARD_LOW]};  // R15
                        lock_d  = lock_q | byte_next[`SSP_BIT_SERIAL_LOCK];  // R08
                        latch_d = 1'b0;                             // R17
                    end
                    ssp_pkg::SSP_IGNORE:
                        state_d = ssp_pkg::SSP_IGNORE;
                endcase
            end
        end

        if (nv_restore_valid && !commit)
        begin
            pge_d   = nv_restore_byte[`SSP_BIT_PIN_GUARD_EN];
            guard_d = {nv_restore_byte[`SSP_BIT_GUARD_HIGH], nv_restore_byte[`SSP_BIT_GUARD_LOW]};
            lock_d  = lock_q | nv_restore_byte[`SSP_BIT_SERIAL_LOCK];  // R08
        end
        if (nv_save_done)
            image_d = status_now & 8'hcc;                           // R13
    end

    // =================================================================
    // Registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q      <= ssp_pkg::SSP_OPCODE;
            cnt_q        <= 3'h0;
            sh_in_q      <= 8'h00;
            sh_out_q     <= 8'h00;
            sck_prev_q   <= 1'b1;
            cs_prev_q    <= 1'b1;
            so_q         <= 1'b0;
            latch_q      <= 1'b0;                                   // R06
            pge_q        <= 1'b0;                                   // R05
            lock_q       <= 1'b0;
            guard_q      <= 2'h0;
            busy_q       <= 1'b0;
            pend_clear_q <= 1'b0;
            pend_op_q    <= 1'b0;
            pend_code_q  <= 8'h00;
            go_q         <= 1'b0;
            go_code_q    <= 8'h00;
            image_q      <= `SSP_STATUS_RESET;
        end
        else if (clk_en)
        begin
            state_q      <= state_d;
            cnt_q        <= cnt_d;
            sh_in_q      <= sh_in_d;
            sh_out_q     <= sh_out_d;
            sck_prev_q   <= sck_prev_d;
            cs_prev_q    <= cs_prev_d;
            so_q         <= so_d;
            latch_q      <= latch_d;
            pge_q        <= pge_d;
            lock_q       <= lock_d;
            guard_q      <= guard_d;
            busy_q       <= busy_d;
            pend_clear_q <= pend_clear_d;
            pend_op_q    <= pend_op_d;
            pend_code_q  <= pend_code_d;
            go_q         <= go_d;
            go_code_q    <= go_code_d;
            image_q      <= image_d;
        end
    end

    // =================================================================
    // Array protection
    ssp_guard u_guard
    (
        .block_guard    (guard_q),
        .addr           (array_addr),
        .addr_protected (array_addr_protected)                      // R15
    );

    assign so              = so_q;
    assign so_oe           = sel & (state_q == ssp_pkg::SSP_READ);
    assign status_byte     = status_now;
    assign nv_status_image = image_q;
    assign write_cmd_go    = go_q;
    assign write_cmd_code  = go_code_q;

    // =================================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_unused_zero: assert property (status_byte[5:4] == 2'h0)  // R04
        else $error("unused status bits not zero");
    a_busy_mirror: assert property ($past(clk_en) |-> status_byte[0] == $past(busy_in))  // R02
        else $error("busy bit does not follow activity");
    a_lock_sticky: assert property ($past(lock_q) |-> lock_q)  // R08
        else $error("serial lock returned to zero");
    a_latch_set: assert property (clk_en && done && state_q == ssp_pkg::SSP_OPCODE
                                  && byte_next == `SSP_OP_LATCH_SET |=> latch_q)  // R16
        else $error("latch-set command did not set latch");
    a_clear_rise: assert property (clk_en && cs_rise && pend_clear_q |=> !latch_q)  // R18
        else $error("latch not cleared at select rise");
    a_write_gated: assert property ($rose(state_q == ssp_pkg::SSP_WDATA) |-> $past(latch_q && !pin_block))  // R12 R19
        else $error("status write committed without latch");
    a_commit_clear: assert property (clk_en && commit |=> !latch_q)  // R17
        else $error("latch left set after status write");
    a_guard_block: assert property (clk_en && done && state_q == ssp_pkg::SSP_OPCODE && pin_block
                                    && byte_next == `SSP_OP_STATUS_WRITE |=> state_q != ssp_pkg::SSP_WDATA)  // R19
        else $error("guard pin failed to block status write");
    a_full_level: assert property (guard_q == 2'h3 |-> array_addr_protected)  // R15
        else $error("full guard level left address writable");
    a_short_frame: assert property (state_q == ssp_pkg::SSP_WDATA && !sel |=> $stable(guard_q) && $stable(pge_q))  // R20
        else $error("short frame changed status");

    c_plain_read: cover property (state_q == ssp_pkg::SSP_OPCODE ##1 state_q == ssp_pkg::SSP_READ);
    c_quick_read: cover property (state_q == ssp_pkg::SSP_DUMMY ##1 state_q == ssp_pkg::SSP_READ);
    c_status_wr:  cover property (commit);
    c_other_go:   cover property (write_cmd_go);

endmodule
`default_nettype wire

/* File: verification/ssp_host.sv */
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// SPI host model, mode 0, 16 clk per sck period
module ssp_host
(
    input  wire logic clk,
    input  wire logic so,
    output logic      sck,
    output logic      cs_n,
    output logic      si
);
    initial
    begin
        sck  = 1'h0;
        cs_n = 1'h1;
        si   = 1'h0;
    end

    task automatic half();
        repeat (8) @(negedge clk);
    endtask

    // One frame: n bits of d, MSB first; last eight so bits kept
    task automatic frame(input logic [23:0] d, input int n, output logic [7:0] rx);
        rx = 8'h00;
        @(negedge clk);
        cs_n = 1'h0;
        half();
        for (int k = n - 1; k >= 0; k--)
        begin
            si = d[k];
            half();
            sck = 1'h1;
            rx  = {rx[6:0], so};
            half();
            sck = 1'h0;
        end
        half();
        cs_n = 1'h1;
        si   = ~si;
        half();
        half();
    endtask
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, g); end end

module tb_top;
    logic        clk;
    logic        resetn;
    logic        clk_en;
    logic        sck;
    logic        cs_n;
    logic        si;
    logic        wp_n;
    logic        busy_in;
    logic        nv_save_done;
    logic        nv_restore_valid;
    logic [7:0]  nv_restore_byte;
    logic [15:0] array_addr;
    logic        so;
    logic        so_oe;
    logic [7:0]  status_byte;
    logic [7:0]  nv_status_image;
    logic        array_addr_protected;
    logic        write_cmd_go;
    logic [7:0]  write_cmd_code;
    logic [31:0] lfsr;
    logic [7:0]  exp_st;
    logic [7:0]  rx;
    logic [7:0]  ops [7];
    logic [15:0] bnd [4];
    int          fail_count;
    int          comparisons;
    int          go_cnt;
    int          cycles;

    ssp_status i_ssp_status
    (
        .clk                  (clk),
        .resetn               (resetn),
        .clk_en               (clk_en),
        .sck                  (sck),
        .cs_n                 (cs_n),
        .si                   (si),
        .wp_n                 (wp_n),
        .busy_in              (busy_in),
        .nv_save_done         (nv_save_done),
        .nv_restore_valid     (nv_restore_valid),
        .nv_restore_byte      (nv_restore_byte),
        .array_addr           (array_addr),
        .so                   (so),
        .so_oe                (so_oe),
        .status_byte          (status_byte),
        .nv_status_image      (nv_status_image),
        .array_addr_protected (array_addr_protected),
        .write_cmd_go         (write_cmd_go),
        .write_cmd_code       (write_cmd_code)
    );

    ssp_host i_ssp_host
    (
        .clk  (clk),
        .so   (so_oe ? so : ~so),
        .sck  (sck),
        .cs_n (cs_n),
        .si   (si)
    );

    // =====================================================================
    // Clock, pulse counter, timeout
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (write_cmd_go === 1'h1)
            go_cnt <= go_cnt + 1;
        if (cycles == 60000)
        begin
            fail_count++;
            close_out();
        end
    end

    // =====================================================================
    // Expectation helpers
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic prot(input logic [1:0] g, input logic [15:0] a);
        return (g == 2'h3) || (g == 2'h2 && a >= 16'h8000) || (g == 2'h1 && a >= 16'hc000);
    endfunction

    function automatic logic [7:0] after_wr(input logic [7:0] o, input logic [7:0] v);
        return {v[7], o[6] | v[6], 2'h0, v[3:2], 1'h0, o[0]};
    endfunction

    // =====================================================================
    // Link tasks
    task automatic sp(input logic [23:0] d, input int n);
        i_ssp_host.frame(d, n, rx);
    endtask

    task automatic chk_st();
        `CHK("status byte", exp_st, status_byte)
        sp({8'h00, `SSP_OP_STATUS_READ, 8'h00}, 16);
        `CHK("plain read", exp_st, rx)
        sp({`SSP_OP_STATUS_QUICK, 16'h0000}, 24);
        `CHK("quick read", exp_st, rx)
    endtask

    task automatic latch_on();
        sp({16'h0000, `SSP_OP_LATCH_SET}, 8);
        exp_st[1] = 1'h1;
        `CHK("latch set", exp_st, status_byte)
    endtask

    task automatic status_write_cmd(input logic [7:0] v, input logic en);
        if (en)
            latch_on();
        sp({8'h00, `SSP_OP_STATUS_WRITE, v}, 16);
        if (exp_st[1] && !(exp_st[7] && !wp_n))
            exp_st = after_wr(exp_st, v);
        chk_st();
    endtask

    task automatic wcls(input logic [7:0] op, input logic en, input logic go);
        int g;
        g = go_cnt;
        if (en)
            latch_on();
        sp({16'h0000, op}, 8);
        `CHK("go pulses", go ? 1 : 0, go_cnt - g)
        if (go)
            `CHK("go code", op, write_cmd_code)
        if (en && !go)
            sp({16'h0000, `SSP_OP_LATCH_CLEAR}, 8);
        exp_st[1] = 1'h0;
        `CHK("latch after", exp_st, status_byte)
    endtask

    task automatic close_out();
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // =====================================================================
    // Main sequence
    initial
    begin
        resetn           = 1'h0;
        clk_en           = 1'h1;
        wp_n             = 1'h1;
        busy_in          = 1'h0;
        nv_save_done     = 1'h0;
        nv_restore_valid = 1'h0;
        nv_restore_byte  = 8'h00;
        array_addr       = 16'h0000;
        lfsr             = 32'h4edb7cd1;
        exp_st           = 8'h00;
        fail_count       = 0;
        comparisons      = 0;
        go_cnt           = 0;
        cycles           = 0;
        ops = '{`SSP_OP_ARRAY_WRITE, `SSP_OP_CLOCK_WRITE, `SSP_OP_NV_SAVE, `SSP_OP_NV_RESTORE,
                `SSP_OP_AUTOSAVE_ON, `SSP_OP_AUTOSAVE_OFF, `SSP_OP_SERIAL_WRITE};
        bnd = '{16'hc000, 16'hbfff, 16'h8000, 16'h7fff};
        repeat (12) @(negedge clk);
        resetn = 1'h1;
        repeat (4) @(negedge clk);
        `CHK("reset status", 8'h00, status_byte)
        `CHK("reset image", 8'h00, nv_status_image)
        `CHK("idle output enable", 1'h0, so_oe)
        chk_st();
        lfsr = step(lfsr);
        status_write_cmd(lfsr[7:0], 1'h0);
        for (int g = 0; g < 4; g++)
        begin
            lfsr = step(lfsr);
            status_write_cmd((lfsr[7:0] & 8'h33) | 8'(g << 2), 1'h1);
            for (int k = 0; k < 8; k++)
            begin
                lfsr = step(lfsr);
                array_addr = (k < 4) ? bnd[k] : lfsr[15:0];
                @(negedge clk);
                `CHK("protected", prot(exp_st[3:2], array_addr), array_addr_protected)
            end
        end
        latch_on();
        sp({12'h000, `SSP_OP_STATUS_WRITE, 4'hf}, 12);
        `CHK("short frame", exp_st, status_byte)
        sp({16'h0000, `SSP_OP_LATCH_CLEAR}, 8);
        exp_st[1] = 1'h0;
        `CHK("latch clear", exp_st, status_byte)
        for (int k = 0; k < 7; k++)
            wcls(ops[k], 1'h1, 1'h1);
        wcls(`SSP_OP_ARRAY_WRITE, 1'h0, 1'h0);
        wp_n = 1'h0;
        status_write_cmd(8'h80, 1'h1);
        status_write_cmd(8'h0c, 1'h1);
        wp_n = 1'h1;
        status_write_cmd(8'h40, 1'h1);
        status_write_cmd(8'h00, 1'h1);
        wcls(`SSP_OP_SERIAL_WRITE, 1'h1, 1'h0);
        clk_en    = 1'h0;
        busy_in   = 1'h1;
        repeat (3) @(negedge clk);
        `CHK("frozen busy", exp_st, status_byte)
        clk_en    = 1'h1;
        exp_st[0] = 1'h1;
        repeat (3) @(negedge clk);
        chk_st();
        busy_in   = 1'h0;
        exp_st[0] = 1'h0;
        repeat (3) @(negedge clk);
        `CHK("busy low", exp_st, status_byte)
        status_write_cmd(8'h04, 1'h1);
        nv_save_done = 1'h1;
        @(negedge clk);
        nv_save_done = 1'h0;
        @(negedge clk);
        `CHK("saved image", exp_st & 8'hcc, nv_status_image)
        nv_restore_byte  = 8'h08;
        nv_restore_valid = 1'h1;
        @(negedge clk);
        nv_restore_valid = 1'h0;
        @(negedge clk);
        exp_st = {1'h0, exp_st[6], 2'h0, 2'h2, exp_st[1:0]};
        `CHK("restored", exp_st, status_byte)
        for (int k = 0; k < 8; k++)
        begin
            lfsr = step(lfsr);
            wp_n = lfsr[8];
            status_write_cmd(lfsr[7:0], lfsr[9]);
        end
        latch_on();
        resetn = 1'h0;
        repeat (3) @(negedge clk);
        resetn = 1'h1;
        repeat (4) @(negedge clk);
        exp_st = 8'h00;
        `CHK("reset again", exp_st, status_byte)
        chk_st();
        close_out();
    end
endmodule

`default_nettype wire
